/* verilog/hci_map.svh */
// Offsets, reset values, field positions and timing counts of the host port.
// Assumes a core clock of 250 MHz and a host that honours the strobe timing below.
//
// Contract
// [R1] The host keeps chip select low for an access, and the port ignores both interfaces while it is high.
// [R2] In software control mode one interrupt request output gathers every interrupt source.
// [R3] Each source is masked on its own through the two mask registers at 14H and 15H, and a masked source never raises the request.
// [R4] Pending interrupt status is reported in the two status registers at 19H and 1AH.
// [R5] Bits [1:0] of the global configuration register at 02H choose push-pull high, push-pull low or open-drain low for the request output.
// [R6] In serial mode the host presents input bits so that the port samples each one on the rising shift clock edge.
// [R7] In serial mode output bits change on the falling shift clock edge when the edge select is high and on the rising edge when it is low.
// [R8] In the latch-enable style the address on the multiplexed bus is captured on the falling edge of the latch enable.
// [R9] In the address-strobe style the address on the multiplexed bus is captured on the falling edge of the address strobe.
// [R10] In the latch-enable style a low write strobe starts a write and the port captures the bus data during it.
// [R11] In the address-strobe style the host drives read/write low for a write and high for a read.
// [R12] In the latch-enable style read data is driven onto the bus only while the read strobe is low.
// [R13] In the address-strobe style the data strobe qualifies a transfer, data is sampled when read/write is 0 and driven when it is 1.
// [R14] In the address-strobe style the acknowledge goes low once read data is valid or write data is accepted.
// [R15] In the latch-enable style ready stays low while an access is in progress and goes high when it completes.
// [R16] The host access method is taken from a two-bit mode code at reset: hardware only, serial, address-strobe or latch-enable.
`ifndef HCI_MAP_SVH
`define HCI_MAP_SVH

`define HCI_ADDR_GCF       8'h02
`define HCI_ADDR_MASK_LO   8'h14
`define HCI_ADDR_MASK_HI   8'h15
`define HCI_ADDR_STAT_LO   8'h19
`define HCI_ADDR_STAT_HI   8'h1A

`define HCI_RST_GCF        8'h00
`define HCI_RST_MASK       8'hFF
`define HCI_RST_STAT       8'h00

`define HCI_IRQ_STYLE_MSB  1
`define HCI_IRQ_STYLE_LSB  0
`define HCI_IRQ_OD_LOW     2'h0
`define HCI_IRQ_PP_HIGH    2'h1

`define HCI_SER_READ_BIT   7
`define HCI_SER_CMD_LAST   5'h07
`define HCI_SER_DATA_LAST  5'h0F
`define HCI_SER_DONE       5'h10

`define HCI_CLK_PERIOD_PS  4000
`define HCI_ACCESS_NS      20
`define HCI_ACCESS_CYC     ((`HCI_ACCESS_NS * 1000 + `HCI_CLK_PERIOD_PS - 1) / `HCI_CLK_PERIOD_PS)
`define HCI_STRAP_WAIT     2'h3
`define HCI_RST_PINS       15'h7FFD

`endif

/* verilog/hci_pkg.sv */
// Types shared by the host port: access modes and the parallel access sequencer.
// Assumes the constants of hci_map.svh are included where numbers are needed.
package hci_pkg;

  typedef enum logic [1:0] {
    HCI_MODE_HW,
    HCI_MODE_SERIAL,
    HCI_MODE_PAR_AS,
    HCI_MODE_PAR_ALE
  } hci_mode_e;

  typedef enum logic [1:0] {
    HCI_ACC_IDLE,
    HCI_ACC_WAIT,
    HCI_ACC_DONE
  } hci_acc_e;

endpackage

/* verilog/hci_host_port.sv */
// Host access port: serial shift interface, two multiplexed parallel styles,
// the configuration, mask and status registers and the interrupt request pin.
// Assumes pins are asynchronous to i_clock and that i_irq_src comes from core logic.
`include "hci_map.svh"

module hci_host_port
  import hci_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_cs_n,
  input  wire logic        i_shift_clk,
  input  wire logic        i_serial_in,
  input  wire logic        i_out_edge_select,
  input  wire logic [7:0]  i_ad_in,
  input  wire logic        i_ale_as,
  input  wire logic        i_rd_ds_n,
  input  wire logic        i_wr_rw,
  input  wire logic [15:0] i_irq_src,
  output logic             o_serial_out,
  output logic [7:0]       o_ad_out,
  output logic             o_ad_oe,
  output logic             o_ack_rdy,
  output logic             o_irq_out,
  output logic             o_irq_oe
);

  localparam int PW = 15;

  logic [PW-1:0] pin_meta_r;
  logic [PW-1:0] pin_sync_r;
  logic          cs_s;
  logic          ale_s;
  logic          rds_s;
  logic          wrs_s;
  logic [7:0]    ad_s;
  logic [1:0]    mode_s;
  logic          edge_sel_s;
  logic          ale_prev_r;
  logic [1:0]    strap_cnt_r;
  hci_mode_e     mode_r;

  logic [7:0]    gcf_r;
  logic [15:0]   mask_r;
  logic [15:0]   stat_r;
  logic [15:0]   stat_clr;

  logic          ser_rst_n;
  logic [4:0]    ser_cnt_r;
  logic [6:0]    ser_sh_r;
  logic [7:0]    ser_cmd_r;
  logic [7:0]    ser_wdata_r;
  logic          ser_rreq_r;
  logic          ser_wreq_r;
  logic          sdo_rise_r;
  logic          sdo_fall_r;
  logic [1:0]    rreq_meta_r;
  logic [1:0]    rreq_sync_r;
  logic [1:0]    rreq_prev_r;
  logic          ser_rd_evt;
  logic          ser_wr_evt;
  logic [7:0]    ser_hold_r;

  hci_acc_e      acc_r;
  logic [2:0]    acc_cnt_r;
  logic          acc_write_r;
  logic [7:0]    par_addr_r;
  logic [7:0]    par_rdata_r;
  logic          par_strobe;
  logic          par_is_write;
  logic          par_mode;
  logic          par_rd_evt;
  logic          par_wr_evt;

  logic          rd_evt;
  logic [7:0]    rd_addr;
  logic [7:0]    rd_data;
  logic          wr_evt;
  logic [7:0]    wr_addr;
  logic [7:0]    wr_data;
  logic          irq_pend;
  logic          ad_oe_r;

  // Every pin crosses two flops before the core looks at it. The flops reset to
  // the idle pin levels so that no false latch enable edge follows reset.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta_r <= `HCI_RST_PINS;
      pin_sync_r <= `HCI_RST_PINS;
    end else begin
      pin_meta_r <= {i_out_edge_select, i_mode, i_ad_in, i_wr_rw, i_rd_ds_n, i_ale_as, i_cs_n};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign cs_s       = ~pin_sync_r[0];
  assign ale_s      = pin_sync_r[1];
  assign rds_s      = ~pin_sync_r[2];
  assign wrs_s      = pin_sync_r[3];
  assign ad_s       = pin_sync_r[11:4];
  assign mode_s     = pin_sync_r[13:12];
  assign edge_sel_s = pin_sync_r[14];

  // The mode straps are read once, at the third edge after release, when the
  // synchroniser holds the pin value rather than its reset value.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_cnt_r <= 2'h0;
      mode_r      <= HCI_MODE_HW;
    end else if (strap_cnt_r != `HCI_STRAP_WAIT) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r + 2'h1 == `HCI_STRAP_WAIT) begin
        mode_r <= hci_mode_e'(mode_s); // [R16]
      end
    end
  end

  // Shift clock domain. Chip select high holds the frame counter in reset, so a
  // stray shift clock outside a frame does nothing.
  assign ser_rst_n = i_rst_n & ~i_cs_n; // [R1]

  always_ff @(posedge i_shift_clk or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      ser_cnt_r <= 5'h00;
    end else if (ser_cnt_r != `HCI_SER_DONE) begin
      ser_cnt_r <= ser_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge i_shift_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ser_sh_r    <= 7'h00;
      ser_cmd_r   <= 8'h00;
      ser_wdata_r <= 8'h00;
      ser_rreq_r  <= 1'b0;
      ser_wreq_r  <= 1'b0;
    end else if (!i_cs_n && ser_cnt_r != `HCI_SER_DONE) begin
      ser_sh_r <= {ser_sh_r[5:0], i_serial_in}; // [R6]
      if (ser_cnt_r == `HCI_SER_CMD_LAST) begin
        ser_cmd_r <= {ser_sh_r, i_serial_in};
        if (ser_sh_r[6]) begin
          ser_rreq_r <= ~ser_rreq_r;
        end
      end
      if (ser_cnt_r == `HCI_SER_DATA_LAST && !ser_cmd_r[`HCI_SER_READ_BIT]) begin
        ser_wdata_r <= {ser_sh_r, i_serial_in};
        ser_wreq_r  <= ~ser_wreq_r;
      end
    end
  end

  // The read word is held still by the core before the first output edge can
  // come, which is what makes the two-domain read safe at the bench clock rate.
  always_ff @(posedge i_shift_clk or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      sdo_rise_r <= 1'b0;
    end else if (ser_cnt_r[4:3] == 2'h1 && ser_cmd_r[`HCI_SER_READ_BIT]) begin
      sdo_rise_r <= ser_hold_r[~ser_cnt_r[2:0]]; // [R7]
    end else begin
      sdo_rise_r <= 1'b0;
    end
  end

  always_ff @(negedge i_shift_clk or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      sdo_fall_r <= 1'b0;
    end else if (ser_cnt_r[4:3] == 2'h1 && ser_cmd_r[`HCI_SER_READ_BIT]) begin
      sdo_fall_r <= ser_hold_r[~ser_cnt_r[2:0]]; // [R7]
    end else begin
      sdo_fall_r <= 1'b0;
    end
  end

  assign o_serial_out = edge_sel_s ? sdo_fall_r : sdo_rise_r; // [R7]

  // Request toggles cross into the core; command and write data stay still
  // from the toggle until the next frame, so the core may read them directly.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rreq_meta_r <= 2'h0;
      rreq_sync_r <= 2'h0;
      rreq_prev_r <= 2'h0;
    end else begin
      rreq_meta_r <= {ser_wreq_r, ser_rreq_r};
      rreq_sync_r <= rreq_meta_r;
      rreq_prev_r <= rreq_sync_r;
    end
  end

  assign ser_rd_evt = (rreq_sync_r[0] ^ rreq_prev_r[0]) && mode_r == HCI_MODE_SERIAL;
  assign ser_wr_evt = (rreq_sync_r[1] ^ rreq_prev_r[1]) && mode_r == HCI_MODE_SERIAL;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ser_hold_r <= 8'h00;
    end else if (ser_rd_evt) begin
      ser_hold_r <= rd_data;
    end
  end

  // Parallel side, both styles share the strobe pins.
  assign par_mode     = mode_r == HCI_MODE_PAR_AS || mode_r == HCI_MODE_PAR_ALE;
  assign par_strobe   = (mode_r == HCI_MODE_PAR_ALE) ? (rds_s || !wrs_s) : rds_s; // [R13]
  assign par_is_write = (mode_r == HCI_MODE_PAR_ALE) ? !wrs_s : !wrs_s; // [R10]

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ale_prev_r <= 1'b0;
      par_addr_r <= 8'h00;
    end else begin
      ale_prev_r <= ale_s;
      if (ale_prev_r && !ale_s && cs_s && par_mode) begin
        par_addr_r <= ad_s; // [R8] [R9]
      end
    end
  end

  // The wait state covers the access time; a write takes the bus data at its
  // end so the host has had time to settle it.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_r       <= HCI_ACC_IDLE;
      acc_cnt_r   <= 3'h0;
      acc_write_r <= 1'b0;
    end else begin
      unique case (acc_r)
        HCI_ACC_IDLE: begin
          if (par_mode && cs_s && par_strobe) begin // [R1]
            acc_r       <= HCI_ACC_WAIT;
            acc_cnt_r   <= 3'(`HCI_ACCESS_CYC);
            acc_write_r <= par_is_write; // [R11]
          end
        end
        HCI_ACC_WAIT: begin
          if (acc_cnt_r == 3'h1) begin
            acc_r <= HCI_ACC_DONE;
          end
          acc_cnt_r <= acc_cnt_r - 3'h1;
        end
        HCI_ACC_DONE: begin
          if (!par_strobe || !cs_s) begin
            acc_r <= HCI_ACC_IDLE;
          end
        end
      endcase
    end
  end

  assign par_rd_evt = acc_r == HCI_ACC_IDLE && par_mode && cs_s && par_strobe && !par_is_write;
  assign par_wr_evt = acc_r == HCI_ACC_WAIT && acc_cnt_r == 3'h1 && acc_write_r; // [R10] [R13]

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      par_rdata_r <= 8'h00;
    end else if (par_rd_evt) begin
      par_rdata_r <= rd_data;
    end
  end

  // Read data goes out only while the read strobe (or data strobe with
  // read/write high) and chip select stay low.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ad_oe_r <= 1'b0;
    end else begin
      ad_oe_r <= par_mode && cs_s && par_strobe && !acc_write_r && acc_r != HCI_ACC_IDLE; // [R12] [R13]
    end
  end

  assign o_ad_oe  = ad_oe_r;
  assign o_ad_out = par_rdata_r;

  always_comb begin
    if (mode_r == HCI_MODE_PAR_ALE) begin
      o_ack_rdy = acc_r != HCI_ACC_WAIT; // [R15]
    end else if (mode_r == HCI_MODE_PAR_AS) begin
      o_ack_rdy = acc_r != HCI_ACC_DONE; // [R14]
    end else begin
      o_ack_rdy = 1'b1;
    end
  end

  // One register port serves both interfaces; only one mode is ever live.
  assign rd_evt  = ser_rd_evt || par_rd_evt;
  assign rd_addr = (mode_r == HCI_MODE_SERIAL) ? {1'b0, ser_cmd_r[6:0]} : par_addr_r;
  assign wr_evt  = ser_wr_evt || par_wr_evt;
  assign wr_addr = rd_addr;
  assign wr_data = (mode_r == HCI_MODE_SERIAL) ? ser_wdata_r : ad_s;

  always_comb begin
    unique case (rd_addr)
      `HCI_ADDR_GCF:     rd_data = gcf_r;
      `HCI_ADDR_MASK_LO: rd_data = mask_r[7:0];
      `HCI_ADDR_MASK_HI: rd_data = mask_r[15:8];
      `HCI_ADDR_STAT_LO: rd_data = stat_r[7:0]; // [R4]
      `HCI_ADDR_STAT_HI: rd_data = stat_r[15:8]; // [R4]
      default:           rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gcf_r  <= `HCI_RST_GCF;
      mask_r <= {`HCI_RST_MASK, `HCI_RST_MASK};
    end else if (wr_evt) begin
      if (wr_addr == `HCI_ADDR_GCF) begin
        gcf_r <= wr_data;
      end
      if (wr_addr == `HCI_ADDR_MASK_LO) begin
        mask_r[7:0] <= wr_data; // [R3]
      end
      if (wr_addr == `HCI_ADDR_MASK_HI) begin
        mask_r[15:8] <= wr_data; // [R3]
      end
    end
  end

  // Status clears on read; a source active in the clearing cycle stays pending.
  assign stat_clr = {{8{rd_evt && rd_addr == `HCI_ADDR_STAT_HI}},
                     {8{rd_evt && rd_addr == `HCI_ADDR_STAT_LO}}};

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_r <= {`HCI_RST_STAT, `HCI_RST_STAT};
    end else begin
      stat_r <= (stat_r & ~stat_clr) | i_irq_src; // [R4]
    end
  end

  // A set mask bit blocks its source from the request pin but not from status.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_pend <= 1'b0;
    end else begin
      irq_pend <= |(stat_r & ~mask_r); // [R2] [R3]
    end
  end

  // Hardware mode leaves the pin undriven; open drain only pulls low.
  always_comb begin
    if (mode_r == HCI_MODE_HW) begin
      o_irq_out = 1'b0;
      o_irq_oe  = 1'b0;
    end else if (gcf_r[`HCI_IRQ_STYLE_MSB:`HCI_IRQ_STYLE_LSB] == `HCI_IRQ_OD_LOW) begin
      o_irq_out = 1'b0; // [R5]
      o_irq_oe  = irq_pend;
    end else if (gcf_r[`HCI_IRQ_STYLE_MSB:`HCI_IRQ_STYLE_LSB] == `HCI_IRQ_PP_HIGH) begin
      o_irq_out = irq_pend; // [R5]
      o_irq_oe  = 1'b1;
    end else begin
      o_irq_out = ~irq_pend; // [R5]
      o_irq_oe  = 1'b1;
    end
  end

endmodule // hci_host_port

/* verification/hci_host_port_properties.sv */
// Checker for the host port, watching only its pins.
// Assumes the mode strap moves only while reset is held.
module hci_props (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic [1:0] i_mode,
  input wire logic       i_cs_n,
  input wire logic       i_shift_clk,
  input wire logic       i_out_edge_select,
  input wire logic       i_rd_ds_n,
  input wire logic       i_wr_rw,
  input wire logic       o_serial_out,
  input wire logic       o_ad_oe,
  input wire logic       o_ack_rdy,
  input wire logic       o_irq_oe
);
  logic [3:0] up_r;

  // The strap is taken a few edges after release, so mode checks other than a_le_ready_width wait for it.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) up_r <= 4'h0;
    else if (up_r != 4'hF) up_r <= up_r + 4'h1;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_cs_quiet: assert property (i_cs_n [*6] |-> o_ack_rdy && !o_ad_oe)
    else $error("Port answered while deselected.");
  a_hw_irq_off: assert property (up_r == 4'hF && i_mode == 2'h0 |-> !o_irq_oe)
    else $error("Request pin driven in hardware mode.");
  a_sdo_fall_edge: assert property (!i_cs_n && i_out_edge_select && $changed(o_serial_out)
    |-> !i_shift_clk)
    else $error("Serial out moved off the falling shift edge.");
  a_oe_needs_strobe: assert property (i_rd_ds_n [*7] |-> !o_ad_oe)
    else $error("Bus driven without a strobe.");
  a_le_read_drive: assert property ((up_r == 4'hF && i_mode == 2'h3 && !i_cs_n && !i_rd_ds_n) [*8]
    |-> o_ad_oe)
    else $error("Read data not driven during the read strobe.");
  a_as_write_quiet: assert property (up_r == 4'hF && i_mode == 2'h2 && !i_wr_rw |-> !o_ad_oe)
    else $error("Bus driven during a write.");
  a_as_ack_soon: assert property (up_r == 4'hF && i_mode == 2'h2 && !i_cs_n && $fell(i_rd_ds_n)
    |-> ##[4:14] !o_ack_rdy)
    else $error("Acknowledge missing.");
  a_le_ready_width: assert property (i_mode == 2'h3 && $fell(o_ack_rdy)
    |-> !o_ack_rdy [*5] ##1 o_ack_rdy)
    else $error("Ready low for the wrong span.");
  a_idle_ready: assert property ((i_rd_ds_n && i_wr_rw) [*7] |-> o_ack_rdy)
    else $error("Handshake output stuck low when idle.");
endmodule // hci_props

bind hci_host_port hci_props u_props (.i_clock, .i_rst_n, .i_mode, .i_cs_n, .i_shift_clk,
  .i_out_edge_select, .i_rd_ds_n, .i_wr_rw, .o_serial_out, .o_ad_oe, .o_ack_rdy, .o_irq_oe);

/* verification/hci_host_model.sv */
// Serial host model: frames of 16 shift clocks at an 80 ns period.
// Assumes the bench keeps the parallel chip select high while it runs.
module hci_host_model (
  output logic      o_cs_n,
  output logic      o_shift_clk,
  output logic      o_serial_in,
  input  wire logic i_serial_out,
  input  wire logic i_out_edge_select
);
  timeunit 1ns;
  timeprecision 100ps;

  // The shift clock stands low between frames, as a real host leaves it.
  initial begin
    o_cs_n = 1'b1;
    o_shift_clk = 1'b0;
    o_serial_in = 1'b0;
  end

  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    #1.3 o_cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      #20 o_serial_in = sh[15 - i];
      #20 o_shift_clk = 1'b1;
      if (i > 7 && i_out_edge_select) rd = {rd[6:0], i_serial_out};
      #40 o_shift_clk = 1'b0;
      if (i > 7 && !i_out_edge_select) rd = {rd[6:0], i_serial_out};
    end
    #40 o_cs_n = 1'b1;
    // A released line must not keep looking like valid data.
    o_serial_in = ~o_serial_in;
  endtask
endmodule // hci_host_model

/* verification/testbench.sv */
// Self-checking bench for the host port in all four access modes.
// Assumes the serial host model and the bound checker are compiled with it.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        p_cs_n = 1'b1;
  logic        ale = 1'b0;
  logic        rd_n = 1'b1;
  logic        wr = 1'b1;
  logic        esel = 1'b1;
  logic [1:0]  mode = 2'h3;
  logic [7:0]  ad = 8'h00;
  logic [7:0]  q;
  logic [15:0] src = 16'h0000;
  logic [7:0]  ra [5] = '{8'h02, 8'h14, 8'h15, 8'h19, 8'h1A};
  logic [7:0]  re [5] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
  wire         s_cs_n, sclk, serial_in, serial_out, oe, rdy, irq, irq_oe;
  wire  [7:0]  ado;
  int          miscompares = 0;
  int          n_tests = 0;

  always #2 clk = ~clk;

  hci_host_port u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_mode(mode),
    .i_cs_n(p_cs_n & s_cs_n), .i_shift_clk(sclk), .i_serial_in(serial_in), .i_out_edge_select(esel),
    .i_ad_in(oe ? ado : ad), .i_ale_as(ale), .i_rd_ds_n(rd_n), .i_wr_rw(wr), .i_irq_src(src),
    .o_serial_out(serial_out), .o_ad_out(ado), .o_ad_oe(oe), .o_ack_rdy(rdy), .o_irq_out(irq),
    .o_irq_oe(irq_oe));
  hci_host_model u_host (.o_cs_n(s_cs_n), .o_shift_clk(sclk), .o_serial_in(serial_in),
    .i_serial_out(serial_out), .i_out_edge_select(esel));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic boot(input logic [1:0] m);
    @(negedge clk) rst_n = 1'b0;
    mode = m;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // One parallel access; no handshake is expected when deselected or not parallel.
  task automatic acc(input logic c, input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int   n;
    logic ig;
    ig = c | (mode < 2'h2);
    n = 0;
    @(negedge clk) p_cs_n = c;
    ale = 1'b1;
    ad = a;
    repeat (4) @(negedge clk);
    ale = 1'b0;
    repeat (5) @(negedge clk);
    ad = d;
    wr = !w;
    @(negedge clk) rd_n = (mode == 2'h3) ? w : 1'b0;
    while (rdy !== 1'b0 && n < 30) begin @(negedge clk); n++; end
    if (mode == 2'h3) while (rdy !== 1'b1 && n < 30) begin @(negedge clk); n++; end
    r = ado;
    chk({6'h00, n >= 30, oe}, {6'h00, ig, !w && !ig});
    rd_n = 1'b1;
    wr = 1'b1;
    repeat (7) @(negedge clk);
    p_cs_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  task automatic pulse(input logic [15:0] v);
    @(negedge clk) src = v;
    @(negedge clk) src = 16'h0000;
    repeat (4) @(negedge clk);
  endtask

  task automatic give_verdict();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    boot(2'h3);
    chk({5'h00, irq_oe, rdy, oe}, 8'h02);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 1'b0, ra[i], 8'h00, q);
      chk(q, re[i]);
    end
    acc(1'b0, 1'b0, 8'h03, 8'h00, q);
    chk(q, 8'h00);
    acc(1'b0, 1'b1, 8'h19, 8'hFF, q);
    acc(1'b0, 1'b0, 8'h19, 8'h00, q);
    chk(q, 8'h00);
    acc(1'b0, 1'b1, 8'h14, 8'hFE, q);
    pulse(16'h0102);
    chk({6'h00, irq_oe, irq}, 8'h00);
    pulse(16'h0001);
    chk({6'h00, irq_oe, irq}, 8'h02);
    for (int s = 0; s < 4; s++) begin
      acc(1'b0, 1'b1, 8'h02, 8'(s), q);
      chk({6'h00, irq_oe, irq}, (s == 1) ? 8'h03 : 8'h02);
    end
    acc(1'b1, 1'b1, 8'h02, 8'h00, q);
    acc(1'b0, 1'b0, 8'h02, 8'h00, q);
    chk(q, 8'h03);
    acc(1'b0, 1'b0, 8'h19, 8'h00, q);
    chk(q, 8'h03);
    acc(1'b0, 1'b0, 8'h1A, 8'h00, q);
    chk(q, 8'h01);
    acc(1'b0, 1'b0, 8'h19, 8'h00, q);
    chk(q, 8'h00);
    chk({6'h00, irq_oe, irq}, 8'h03);
    $display("latch-enable test done");
    boot(2'h2);
    acc(1'b0, 1'b1, 8'h15, 8'hFE, q);
    acc(1'b0, 1'b0, 8'h15, 8'h00, q);
    chk(q, 8'hFE);
    acc(1'b0, 1'b1, 8'h02, 8'h01, q);
    pulse(16'h0100);
    chk({6'h00, irq_oe, irq}, 8'h03);
    $display("address-strobe test done");
    boot(2'h1);
    u_host.xfer(8'h02, 8'h01, q);
    for (int e = 0; e < 2; e++) begin
      @(negedge clk) esel = e[0];
      repeat (8) @(negedge clk);
      u_host.xfer(8'h82, 8'h00, q);
      chk(q, 8'h01);
    end
    acc(1'b0, 1'b1, 8'h02, 8'h00, q);
    $display("serial test done");
    boot(2'h0);
    acc(1'b0, 1'b1, 8'h02, 8'h01, q);
    chk({7'h00, irq_oe}, 8'h00);
    $display("hardware mode test done");
    give_verdict();
  end

  // The tests need about 7 us; a hang is cut off well beyond that.
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule // testbench
